//--- debug_host.sv
// Model of the external debug host: test-port reset pin and debug flash reads.
// Assumes requests change just after a rising edge of clock.
`timescale 1ns/100ps
`default_nettype none
module debug_host
    import flash_security_pkg::*;
(
    // Clock
    input wire logic clock,
    // Debug port
    output logic tap_reset_n,
    output logic dbg_rd,
    output var dbg_req_t dbg_req,
    input wire logic [15:0] dbg_rdata,
    input wire logic dbg_denied
);
    initial begin
        tap_reset_n = 1'b1;
        dbg_rd = 1'b0;
        dbg_req = '0;
    end
    // A released address shows its inverse so stale values never look valid.
    task read(input logic [14:0] a);
        @(posedge clock) begin
            dbg_rd <= 1'b1;
            dbg_req <= {a, 16'h0000};
        end
        @(posedge clock) begin
            dbg_rd <= 1'b0;
            dbg_req <= {~a, 16'hffff};
        end
        #1;
    endtask
    task tap_pulse;
        @(posedge clock) tap_reset_n <= 1'b0;
        repeat (4) @(posedge clock);
        tap_reset_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
endmodule
`default_nettype wire

//--- flash_security_defines.svh
// Constants for the flash security interlock: word addresses, field positions, reset values.
// Assumes a 16-bit flash word with a 15-bit word address.
`ifndef FLASH_SECURITY_DEFINES_SVH
`define FLASH_SECURITY_DEFINES_SVH

`define SEC_WORD_ADDR 15'h7ff7
`define KEY0_ADDR 15'h7ffc
`define KEY3_ADDR 15'h7fff
`define SEC_UNSECURE_VALUE 16'h0000
`define SEC_BIT_HI 1
`define SEC_BIT_LO 0
`define ERASED_WORD 16'hffff
`define KEY_WORDS 4

`endif

//--- flash_security_pkg.sv
// Types shared by the flash security interlock files.
// Assumes flash_security_defines.svh is on the include path.
package flash_security_pkg;

    typedef struct packed {
        logic rd;
        logic wr;
        logic erase;
        logic [14:0] addr;
        logic [15:0] wdata;
    } flash_req_t;

    typedef struct packed {
        logic [14:0] addr;
        logic [15:0] data;
    } dbg_req_t;

endpackage

//--- flash_security_unlock.sv
// Flash security interlock: holds the flash array, the security word and the debug gate.
// Assumes software and debug requests are synchronous to clock; tap_reset_n is a pin.
`timescale 1ns/100ps
`default_nettype none
`include "flash_security_defines.svh"

module flash_security_unlock
    import flash_security_pkg::*;
#(
    parameter int ADDR_W = 15,
    parameter int DEPTH = 32768
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic tap_reset_n,
    // Software flash port
    input wire flash_req_t sw_req,
    output logic [15:0] sw_rdata,
    // Debug emulation port flash reads
    input wire logic dbg_rd,
    input wire dbg_req_t dbg_req,
    output logic [15:0] dbg_rdata,
    output logic dbg_denied,
    // Mass erase request from the test port
    input wire logic mass_erase,
    // Status
    output logic secured,
    output logic debug_emulation_port_enable,
    output logic key_failed
);

    logic rst_meta_reg;
    logic rst_n;
    logic tap_meta_reg;
    logic tap_sync_reg;
    logic tap_prev_reg;
    logic [15:0] mem [DEPTH];
    logic sampled_reg;
    logic sampled_next;
    logic boot_prot;
    logic prot_reg;
    logic prot_next;
    logic bypass_reg;
    logic bypass_next;
    logic tap_seen_reg;
    logic tap_seen_next;
    logic [15:0] sw_rdata_next;
    logic [15:0] dbg_rdata_next;
    logic denied_next;
    logic match_pulse;
    logic fail_pulse;
    logic key_write;
    logic [15:0] stored_key;
    logic [1:0] key_idx;

    function automatic logic word_secured(input logic [15:0] w);
        return w[`SEC_BIT_HI] && !w[`SEC_BIT_LO];
    endfunction

    // --------------------------------------------------------------
    // Reset release and test-port reset synchroniser
    // --------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tap_meta_reg <= 1'b1;
            tap_sync_reg <= 1'b1;
            tap_prev_reg <= 1'b1;
        end else begin
            tap_meta_reg <= tap_reset_n;
            tap_sync_reg <= tap_meta_reg;
            tap_prev_reg <= tap_sync_reg;
        end
    end

    // --------------------------------------------------------------
    // Flash array: program clears bits, erase sets them
    // --------------------------------------------------------------
    // The array is nonvolatile in intent and has no reset.
    always_ff @(posedge clock) begin
        if (mass_erase) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= `ERASED_WORD;
            end
        end else if (sw_req.wr && !key_write) begin
            mem[sw_req.addr] <= mem[sw_req.addr] & sw_req.wdata;
        end else if (sw_req.erase) begin
            mem[sw_req.addr] <= `ERASED_WORD;
        end
    end

    // --------------------------------------------------------------
    // Back-door key comparison
    // --------------------------------------------------------------
    assign key_write = sw_req.wr && (sw_req.addr >= `KEY0_ADDR) && prot_reg;
    assign key_idx = sw_req.addr[1:0];
    assign stored_key = mem[{13'h1fff, key_idx}];

    key_compare u_key_compare (
        .clock(clock),
        .rst_n(rst_n),
        .access(sw_req.rd || sw_req.wr || sw_req.erase),
        .key_write(key_write && (key_idx == 2'(`KEY_WORDS - 1) ? 1'b1 : key_write)),
        .key_data(sw_req.wdata),
        .stored_word(stored_key),
        .match_pulse(match_pulse),
        .fail_pulse(fail_pulse)
    );

    // --------------------------------------------------------------
    // Security state
    // --------------------------------------------------------------
    always_comb begin
        sampled_next = 1'b1;
        prot_next = prot_reg;
        bypass_next = bypass_reg;
        tap_seen_next = tap_seen_reg;
        // Reprogramming the security word asks for a fresh test-port reset.
        if (sw_req.wr && !key_write && sw_req.addr == `SEC_WORD_ADDR) begin
            tap_seen_next = 1'b0;
        end
        if (mass_erase) begin
            tap_seen_next = 1'b0;
        end
        if (!tap_sync_reg && tap_prev_reg) begin
            tap_seen_next = 1'b1;
        end
        // A zero word unsecures only once the test port has been reset as well.
        boot_prot = word_secured(mem[`SEC_WORD_ADDR])
            || (mem[`SEC_WORD_ADDR] == `SEC_UNSECURE_VALUE && !tap_seen_reg);
        if (!sampled_reg) begin
            prot_next = boot_prot;
        end
        if (mass_erase) begin
            prot_next = 1'b0;
        end
        if (match_pulse) begin
            bypass_next = 1'b1;
        end
        if (fail_pulse) begin
            bypass_next = 1'b0;
        end
        sw_rdata_next = mem[sw_req.addr];
        denied_next = dbg_rd && prot_reg && !bypass_reg;
        dbg_rdata_next = (dbg_rd && !denied_next) ? mem[dbg_req.addr] : 16'h0000;
    end

    // The security word is sampled when reset releases, so a key unlock lasts only until the next reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sampled_reg <= 1'b0;
            prot_reg <= 1'b1;
            bypass_reg <= 1'b0;
            sw_rdata <= 16'h0000;
            dbg_rdata <= 16'h0000;
            dbg_denied <= 1'b0;
            secured <= 1'b1;
            debug_emulation_port_enable <= 1'b0;
            key_failed <= 1'b0;
        end else begin
            sampled_reg <= sampled_next;
            prot_reg <= prot_next;
            bypass_reg <= bypass_next;
            sw_rdata <= sw_rdata_next;
            dbg_rdata <= dbg_rdata_next;
            dbg_denied <= denied_next;
            secured <= prot_next && !bypass_next;
            debug_emulation_port_enable <= !(prot_next && !bypass_next);
            key_failed <= fail_pulse;
        end
    end

    // Test-port reset history lives with the flash state and survives device resets.
    always_ff @(posedge clock) begin
        tap_seen_reg <= tap_seen_next;
    end

endmodule

`default_nettype wire

//--- flash_security_unlock_props.sv
// Checker for the flash security interlock, bound to its top module.
// Assumes the defines header and the package are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "flash_security_defines.svh"
module flash_security_unlock_chk
    import flash_security_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Watched ports
    input wire flash_req_t sw_req,
    input wire logic dbg_rd,
    input wire logic [15:0] dbg_rdata,
    input wire logic dbg_denied,
    input wire logic mass_erase,
    input wire logic secured,
    input wire logic debug_emulation_port_enable,
    input wire logic key_failed
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    logic [3:0] since_rst_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            since_rst_reg <= 4'h0;
        end else if (since_rst_reg != 4'hf) begin
            since_rst_reg <= since_rst_reg + 4'h1;
        end
    end
    chk_enable_inverse: assert property (debug_emulation_port_enable == !secured)
        else $error("debug enable does not mirror secured");
    chk_denied_read: assert property (dbg_rd && secured |=> dbg_denied && dbg_rdata == 16'h0000)
        else $error("debug read not refused while secured");
    chk_open_read: assert property (dbg_rd && !secured |=> !dbg_denied)
        else $error("debug read refused while open");
    chk_denied_cause: assert property (dbg_denied |-> $past(dbg_rd))
        else $error("refusal without a debug read");
    chk_fail_pulse: assert property (key_failed |=> !key_failed)
        else $error("key failure longer than one cycle");
    chk_fail_holds: assert property (key_failed && secured |=> secured [*2])
        else $error("failed key opened the device");
    chk_unlock_cause: assert property ($fell(secured) && since_rst_reg > 4'h7 |->
        $past(mass_erase) || $past(sw_req.wr && sw_req.addr == `KEY3_ADDR, 2))
        else $error("security dropped without erase or key");
    chk_reset_secured: assert property ($rose(resetn) |-> secured ##1 secured)
        else $error("not secured on leaving reset");
    cover property (dbg_rd && secured);
    cover property ($fell(secured));
    cover property (key_failed);
endmodule
bind flash_security_unlock flash_security_unlock_chk u_chk (.clock, .resetn, .sw_req, .dbg_rd,
    .dbg_rdata, .dbg_denied, .mass_erase, .secured, .debug_emulation_port_enable, .key_failed);
`default_nettype wire

//--- key_compare.sv
// Back-door key sequencer: watches flash accesses for four consecutive key writes.
// Assumes the requests come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module key_compare
    import flash_security_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Access stream
    input wire logic access,
    input wire logic key_write,
    input wire logic [15:0] key_data,
    input wire logic [15:0] stored_word,
    // Result
    output logic match_pulse,
    output logic fail_pulse
);

    logic [2:0] count_reg;
    logic [2:0] count_next;
    logic ok_reg;
    logic ok_next;
    logic match_next;
    logic fail_next;

    // --------------------------------------------------------------
    // Sequence tracking
    // --------------------------------------------------------------
    always_comb begin
        count_next = count_reg;
        ok_next = ok_reg;
        match_next = 1'b0;
        fail_next = 1'b0;
        if (access) begin
            if (key_write) begin
                if (count_reg == 3'(`KEY_WORDS - 1)) begin
                    count_next = 3'h0;
                    ok_next = 1'b1;
                    match_next = ok_reg && (key_data == stored_word);
                    fail_next = !(ok_reg && (key_data == stored_word));
                end else begin
                    count_next = count_reg + 3'h1;
                    ok_next = ok_reg && (key_data == stored_word);
                end
            end else begin
                // Any other flash access breaks the sequence.
                fail_next = (count_reg != 3'h0);
                count_next = 3'h0;
                ok_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 3'h0;
            ok_reg <= 1'b1;
            match_pulse <= 1'b0;
            fail_pulse <= 1'b0;
        end else begin
            count_reg <= count_next;
            ok_reg <= ok_next;
            match_pulse <= match_next;
            fail_pulse <= fail_next;
        end
    end

endmodule

`default_nettype wire

//--- tb.sv
// Testbench: erase, programming, key unlock and reset routes of the interlock.
// Assumes the debug host model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "flash_security_defines.svh"
module tb
    import flash_security_pkg::*;
;
    logic clock = 0, resetn = 0, mass_erase = 0, tap_reset_n, dbg_rd, dbg_denied;
    logic secured, debug_emulation_port_enable, key_failed;
    logic [15:0] sw_rdata, dbg_rdata;
    flash_req_t sw_req = '0;
    dbg_req_t dbg_req;
    int miscompares = 0, n_checks = 0, fails = 0, f0;
    logic [15:0] key [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
    flash_security_unlock dut (.clock, .resetn, .tap_reset_n, .sw_req, .sw_rdata, .dbg_rd,
        .dbg_req, .dbg_rdata, .dbg_denied, .mass_erase, .secured,
        .debug_emulation_port_enable, .key_failed);
    debug_host host (.clock, .tap_reset_n, .dbg_rd, .dbg_req, .dbg_rdata, .dbg_denied);
    initial forever #20 clock = ~clock;
    always @(posedge clock) if (key_failed === 1'b1) fails++;
    task check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task sw(input logic rd, input logic wr, input logic [14:0] a, input logic [15:0] d);
        @(posedge clock) sw_req <= {rd, wr, 1'b0, a, d};
        @(posedge clock) sw_req <= '0;
        #1;
    endtask
    task rst;
        @(posedge clock) resetn <= 1'b0;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
    endtask
    task key_seq(input logic [15:0] bad);
        for (int i = 0; i < 4; i++)
            @(posedge clock) sw_req <= {2'b01, 1'b0, `KEY0_ADDR + i[14:0], key[i] ^ (i == 2 ? bad : 16'h0)};
        @(posedge clock) sw_req <= '0;
        repeat (4) @(posedge clock);
        #1;
    endtask
    task s_erase;
        @(posedge clock) mass_erase <= 1'b1;
        @(posedge clock);
        for (int n = 0; n < 40000 && secured !== 1'b0; n++) @(posedge clock);
        mass_erase <= 1'b0;
        check(secured, 0);
        sw(1, 0, `SEC_WORD_ADDR, 0);
        check(sw_rdata, `ERASED_WORD);
    endtask
    task s_program;
        sw(0, 1, 15'h0100, 16'h00ff);
        sw(0, 1, 15'h0100, 16'hff0f);
        sw(1, 0, 15'h0100, 0);
        check(sw_rdata, 16'h000f);
        for (int i = 0; i < 4; i++) sw(0, 1, `KEY0_ADDR + i[14:0], key[i]);
        sw(0, 1, `SEC_WORD_ADDR, 16'hfffe);
        rst;
        check(secured, 1);
        check(debug_emulation_port_enable, 0);
        host.read(15'h0100);
        check({dbg_denied, dbg_rdata}, {1'b1, 16'h0000});
    endtask
    task s_bad_key;
        f0 = fails;
        key_seq(16'h0001);
        check(fails - f0, 1);
        check(secured, 1);
        host.read(15'h0100);
        check(dbg_denied, 1);
        sw(1, 0, `KEY0_ADDR + 15'h2, 0);
        check(sw_rdata, key[2]);
    endtask
    task s_good_key;
        key_seq(16'h0000);
        check(secured, 0);
        host.read(15'h0100);
        check({dbg_denied, dbg_rdata}, {1'b0, 16'h000f});
        sw(1, 0, `SEC_WORD_ADDR, 0);
        check(sw_rdata, 16'hfffe);
        rst;
        check(secured, 1);
    endtask
    task s_zero_word;
        sw(0, 1, `SEC_WORD_ADDR, `SEC_UNSECURE_VALUE);
        rst;
        check(secured, 1);
        host.tap_pulse();
        rst;
        check(secured, 0);
        host.read(15'h0100);
        check({dbg_denied, dbg_rdata}, {1'b0, 16'h000f});
    endtask
    initial begin
        mass_erase <= 1'b1;
        @(posedge clock) mass_erase <= 1'b0;
        rst;
        s_erase;
        s_program;
        s_bad_key;
        s_good_key;
        s_zero_word;
        tally_and_finish;
    end
    initial begin
        #2000000;
        miscompares++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
